// file: inc/lpm_pkg.sv
package lpm_pkg;

    // ****************************************
    // Sizes and reset values
    // ****************************************
    localparam int NUM_PERIPH = 8;
    localparam int NUM_EXT_LINES = 8;
    localparam logic [7:0] PCLK_EN_RST = 8'hFF;
    localparam logic [1:0] SYSCLK_DIV_RST = 2'h0;
    localparam logic [1:0] SYSCLK_SRC_HSI = 2'h0;
    localparam logic WDOG_RUN_RST = 1'h0;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_PCLK = 4'h4;
    localparam logic [3:0] ADDR_STAT = 4'h8;
    localparam logic [3:0] ADDR_WDOG = 4'hC;
    localparam int CTRL_DEEP_SLEEP = 0;
    localparam int CTRL_SLEEP_AFTER = 1;
    localparam int CTRL_EV_ON_PEND = 2;
    localparam int CTRL_POWERDOWN_DEEPSLEEP_SELECT = 3;
    localparam int CTRL_LP_REG = 4;
    localparam int CTRL_DIV_LO = 5;
    localparam int CTRL_DIV_HI = 6;
    localparam int WDOG_START = 0;

    // ****************************************
    // Modes
    // ****************************************
    typedef enum logic [2:0] {
        MODE_RUN = 3'h0,
        MODE_SLEEP_IRQ = 3'h1,
        MODE_SLEEP_EVT = 3'h2,
        MODE_STOP_WAIT = 3'h3,
        MODE_STOP = 3'h4,
        MODE_STANDBY = 3'h5
    } mode_e;

    typedef enum logic [1:0] {
        STAT_RUN = 2'h0,
        STAT_SLEEP = 2'h1,
        STAT_STOP = 2'h2,
        STAT_STANDBY = 2'h3
    } stat_e;

    typedef struct packed {
        logic cpu_clk_en;
        logic [7:0] periph_clk_en;
        logic domain_clk_en;
        logic pll_en;
        logic hsi_en;
        logic hse_en;
        logic regulator_on;
        logic domain_power_on;
        logic io_hold;
        logic [1:0] sysclk_src;
        logic [1:0] sysclk_div;
    } clk_ctl_s;

    typedef struct packed {
        logic rtc_clock_enable;
        logic low_speed_xtal_on;
    } backup_ctl_s;

endpackage

// file: rtl/low_power_mode_controller.sv
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
// Operation
// RL1: Reset starts in Run, all clocks on
// RL2: Sleep stops only the CPU clock
// RL3: Stop gates domain clocks, PLL, oscillators
// RL4: Standby powers off domain and regulator
// RL5: Wait instruction, no deep, no after: sleep
// RL6: Sleep-after-handler sleeps on last handler return
// RL7: After-handler via WAIT_FOR_INTERRUPT_INSTR only, irq exit, no latency
// RL8: Accepted interrupt wakes WAIT_FOR_INTERRUPT_INSTR sleep
// RL9: Any event wakes WAIT_FOR_EVENT_INSTR sleep
// RL10: Event-on-pending turns pending irq into event
// RL11: Event-mode external line wakes without pending
// RL12: Pins hold state in Sleep and Stop
// RL13: Stop is deep sleep plus clock gating
// RL14: Stop needs no pending flags, else ignored
// RL15: Flash programming postpones Stop entry
// RL16: APB transfer postpones Stop entry
// RL17: Watchdog once started runs until reset
// RL18: RTC and slow xtal follow backup control
// RL19: Standby exits on pin, alarm, reset, watchdog
// RL20: Standby wake resets like a reset
// RL21: Stop exit selects internal RC clock
// RL22: Run allows clock gating and slowing
// RL23: Mode status output
module low_power_mode_controller (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic wfi_i,
    input wire logic wfe_i,
    input wire logic handler_exit_i,
    input wire logic irq_accepted_i,
    input wire logic periph_irq_pend_i,
    input wire logic [7:0] ext_line_pend_i,
    input wire logic [7:0] ext_line_event_i,
    input wire logic rtc_alarm_flag_i,
    input wire logic rtc_alarm_i,
    input wire logic wakeup_pin_i,
    input wire logic ext_reset_pin_b_i,
    input wire logic wdog_reset_i,
    input wire logic wdog_hw_option_i,
    input wire logic flash_busy_i,
    input wire logic apb_busy_i,
    input wire lpm_pkg::backup_ctl_s backup_ctl_i,
    output lpm_pkg::clk_ctl_s clk_ctl_o,
    output lpm_pkg::backup_ctl_s backup_keep_o,
    output logic wdog_run_o,
    output logic wake_o,
    output logic standby_reset_o,
    output logic [1:0] mode_o
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic [4:0] async_in;
    logic wakeup_pin_s;
    logic alarm_s;
    logic external_reset_pin_s;
    logic wdrst_s;
    logic hwopt_s;
    logic wakeup_pin_d_r;
    logic alarm_d_r;
    logic [4:0] sync1_nxt;
    logic [4:0] sync2_nxt;
    logic wakeup_pin_d_nxt;
    logic alarm_d_nxt;

    assign async_in = {wdog_hw_option_i, wdog_reset_i, ext_reset_pin_b_i, rtc_alarm_i, wakeup_pin_i};

    always_comb begin
        sync1_nxt = async_in;
        sync2_nxt = sync1_r;
        wakeup_pin_d_nxt = sync2_r[0];
        alarm_d_nxt = sync2_r[1];
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            sync1_r <= 5'h04;
            sync2_r <= 5'h04;
            wakeup_pin_d_r <= 1'h0;
            alarm_d_r <= 1'h0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            wakeup_pin_d_r <= wakeup_pin_d_nxt;
            alarm_d_r <= alarm_d_nxt;
        end
    end

    assign wakeup_pin_s = sync2_r[0];
    assign alarm_s = sync2_r[1];
    assign external_reset_pin_s = sync2_r[2];
    assign wdrst_s = sync2_r[3];
    assign hwopt_s = sync2_r[4];

    // ****************************************
    // Register file
    // ****************************************
    logic [6:0] ctrl_r;
    logic [6:0] ctrl_nxt;
    logic [7:0] pclk_r;
    logic [7:0] pclk_nxt;
    logic wdog_r;
    logic wdog_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    lpm_pkg::mode_e mode_r;
    lpm_pkg::mode_e mode_nxt;
    logic after_r;
    logic after_nxt;
    lpm_pkg::stat_e stat;

    function automatic lpm_pkg::stat_e stat_of(input lpm_pkg::mode_e m);
        unique case (m)
            lpm_pkg::MODE_RUN: stat_of = lpm_pkg::STAT_RUN;
            lpm_pkg::MODE_STOP_WAIT: stat_of = lpm_pkg::STAT_RUN;
            lpm_pkg::MODE_SLEEP_IRQ: stat_of = lpm_pkg::STAT_SLEEP;
            lpm_pkg::MODE_SLEEP_EVT: stat_of = lpm_pkg::STAT_SLEEP;
            lpm_pkg::MODE_STOP: stat_of = lpm_pkg::STAT_STOP;
            default: stat_of = lpm_pkg::STAT_STANDBY;
        endcase
    endfunction

    assign stat = stat_of(mode_r);

    always_comb begin
        ctrl_nxt = ctrl_r;
        pclk_nxt = pclk_r;
        if (wr_i) begin
            unique case (addr_i)
                lpm_pkg::ADDR_CTRL: ctrl_nxt = wdata_i[6:0];
                lpm_pkg::ADDR_PCLK: pclk_nxt = wdata_i[7:0]; // RL22
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ctrl_r <= 7'h00;
            pclk_r <= lpm_pkg::PCLK_EN_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
            pclk_r <= pclk_nxt;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    always_comb begin
        rdata_nxt = 32'h0;
        if (rd_i) begin
            unique case (addr_i)
                lpm_pkg::ADDR_CTRL: rdata_nxt = {25'h0, ctrl_r};
                lpm_pkg::ADDR_PCLK: rdata_nxt = {24'h0, pclk_r};
                lpm_pkg::ADDR_STAT: rdata_nxt = {27'h0, mode_r, stat};
                lpm_pkg::ADDR_WDOG: rdata_nxt = {31'h0, wdog_r};
                default: rdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rdata_r <= 32'h0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ****************************************
    // Watchdog run flag
    // ****************************************
    always_comb begin
        wdog_nxt = wdog_r | hwopt_s; // RL17
        if (wr_i && (addr_i == lpm_pkg::ADDR_WDOG)) begin
            wdog_nxt = wdog_r | hwopt_s | wdata_i[lpm_pkg::WDOG_START]; // RL17
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wdog_r <= lpm_pkg::WDOG_RUN_RST;
        end else begin
            wdog_r <= wdog_nxt;
        end
    end

    // ****************************************
    // Mode sequencer
    // ****************************************
    logic deep;
    logic after_h;
    logic ev_pend;
    logic powerdown_deepsleep_select;
    logic flags_pend;
    logic wfe_wake;
    logic stop_block;
    logic standby_wake;
    logic wake_nxt;
    logic sbrst_nxt;
    logic [1:0] src_r;
    logic [1:0] src_nxt;

    assign deep = ctrl_r[lpm_pkg::CTRL_DEEP_SLEEP];
    assign after_h = ctrl_r[lpm_pkg::CTRL_SLEEP_AFTER];
    assign ev_pend = ctrl_r[lpm_pkg::CTRL_EV_ON_PEND];
    assign powerdown_deepsleep_select = ctrl_r[lpm_pkg::CTRL_POWERDOWN_DEEPSLEEP_SELECT];
    assign flags_pend = (|ext_line_pend_i) | periph_irq_pend_i | rtc_alarm_flag_i; // RL14
    assign wfe_wake = (|ext_line_event_i) | (ev_pend & periph_irq_pend_i); // RL10 RL11
    assign stop_block = flash_busy_i | apb_busy_i; // RL15 RL16
    assign standby_wake = (wakeup_pin_s & ~wakeup_pin_d_r) | (alarm_s & ~alarm_d_r) | ~external_reset_pin_s | wdrst_s; // RL19

    always_comb begin
        mode_nxt = mode_r;
        after_nxt = after_r;
        src_nxt = src_r;
        wake_nxt = 1'h0;
        sbrst_nxt = 1'h0;
        unique case (mode_r)
            lpm_pkg::MODE_RUN: begin
                if ((wfi_i | wfe_i) & ~deep & ~after_h) begin
                    mode_nxt = wfi_i ? lpm_pkg::MODE_SLEEP_IRQ : lpm_pkg::MODE_SLEEP_EVT; // RL5
                    after_nxt = 1'h0;
                end else if (handler_exit_i & after_h & ~deep) begin
                    mode_nxt = lpm_pkg::MODE_SLEEP_IRQ; // RL6 RL7
                    after_nxt = 1'h1;
                end else if ((wfi_i | wfe_i) & deep & ~flags_pend) begin // RL14
                    if (powerdown_deepsleep_select) begin
                        mode_nxt = lpm_pkg::MODE_STANDBY;
                    end else begin
                        mode_nxt = lpm_pkg::MODE_STOP_WAIT; // RL13
                    end
                    after_nxt = wfe_i & ~wfi_i;
                end
            end
            lpm_pkg::MODE_SLEEP_IRQ: begin
                if (irq_accepted_i) begin // RL8 RL7
                    mode_nxt = lpm_pkg::MODE_RUN;
                    wake_nxt = 1'h1;
                end
            end
            lpm_pkg::MODE_SLEEP_EVT: begin
                if (wfe_wake) begin // RL9
                    mode_nxt = lpm_pkg::MODE_RUN;
                    wake_nxt = 1'h1;
                end
            end
            lpm_pkg::MODE_STOP_WAIT: begin
                if (!stop_block) begin // RL15 RL16
                    mode_nxt = lpm_pkg::MODE_STOP;
                end
            end
            lpm_pkg::MODE_STOP: begin
                if ((after_r & wfe_wake) | (~after_r & (irq_accepted_i | (|ext_line_pend_i)))) begin
                    mode_nxt = lpm_pkg::MODE_RUN;
                    src_nxt = lpm_pkg::SYSCLK_SRC_HSI; // RL21
                    wake_nxt = 1'h1;
                end
            end
            lpm_pkg::MODE_STANDBY: begin
                if (standby_wake) begin
                    sbrst_nxt = 1'h1; // RL20
                end
            end
            default: mode_nxt = lpm_pkg::MODE_RUN;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            mode_r <= lpm_pkg::MODE_RUN; // RL1
            after_r <= 1'h0;
            src_r <= lpm_pkg::SYSCLK_SRC_HSI;
            wake_o <= 1'h0;
            standby_reset_o <= 1'h0;
        end else begin
            mode_r <= mode_nxt;
            after_r <= after_nxt;
            src_r <= src_nxt;
            wake_o <= wake_nxt;
            standby_reset_o <= sbrst_nxt;
        end
    end

    // ****************************************
    // Mode decoders
    // ****************************************
    function automatic logic clocks_low(input lpm_pkg::mode_e m);
        unique case (m)
            lpm_pkg::MODE_STOP: clocks_low = 1'h1;
            lpm_pkg::MODE_STANDBY: clocks_low = 1'h1;
            default: clocks_low = 1'h0;
        endcase
    endfunction

    function automatic logic power_off(input lpm_pkg::mode_e m);
        unique case (m)
            lpm_pkg::MODE_STANDBY: power_off = 1'h1;
            default: power_off = 1'h0;
        endcase
    endfunction

    function automatic logic cpu_clock_on(input lpm_pkg::mode_e m);
        unique case (m)
            lpm_pkg::MODE_RUN: cpu_clock_on = 1'h1;
            lpm_pkg::MODE_STOP_WAIT: cpu_clock_on = 1'h1;
            default: cpu_clock_on = 1'h0;
        endcase
    endfunction

    function automatic logic pins_held(input lpm_pkg::mode_e m);
        unique case (m)
            lpm_pkg::MODE_RUN: pins_held = 1'h0;
            lpm_pkg::MODE_STANDBY: pins_held = 1'h0;
            default: pins_held = 1'h1;
        endcase
    endfunction

    // ****************************************
    // Clock, power and status outputs
    // ****************************************
    lpm_pkg::clk_ctl_s clk_nxt;
    logic low_clk;
    logic off;

    assign low_clk = clocks_low(mode_nxt);
    assign off = power_off(mode_nxt);

    always_comb begin
        clk_nxt.cpu_clk_en = cpu_clock_on(mode_nxt); // RL2
        clk_nxt.periph_clk_en = low_clk ? 8'h00 : pclk_nxt; // RL3 RL22
        clk_nxt.domain_clk_en = ~low_clk; // RL3
        clk_nxt.pll_en = ~low_clk;
        clk_nxt.hsi_en = ~low_clk;
        clk_nxt.hse_en = ~low_clk;
        clk_nxt.regulator_on = ~off; // RL4
        clk_nxt.domain_power_on = ~off; // RL4
        clk_nxt.io_hold = pins_held(mode_nxt); // RL12
        clk_nxt.sysclk_src = src_nxt;
        clk_nxt.sysclk_div = ctrl_nxt[lpm_pkg::CTRL_DIV_HI:lpm_pkg::CTRL_DIV_LO]; // RL22
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            clk_ctl_o <= {1'h1, lpm_pkg::PCLK_EN_RST, 6'h3F, 1'h0, lpm_pkg::SYSCLK_SRC_HSI, lpm_pkg::SYSCLK_DIV_RST};
            backup_keep_o <= 2'h0;
            wdog_run_o <= lpm_pkg::WDOG_RUN_RST;
            mode_o <= lpm_pkg::STAT_RUN;
        end else begin
            clk_ctl_o <= clk_nxt;
            backup_keep_o <= backup_ctl_i; // RL18
            wdog_run_o <= wdog_nxt; // RL17
            mode_o <= stat_of(mode_nxt); // RL23
        end
    end

    assign rdata_o = rdata_r;

endmodule

// file: sim/lpm_cpu_model.sv
`timescale 1ns/100ps
// ********
// Cpu core and event sources
// ********
module lpm_cpu_model (
    input wire logic clk_i,
    output logic wfi_o,
    output logic wfe_o,
    output logic exit_o,
    output logic irq_o,
    output logic pend_o,
    output logic [7:0] event_o
);
    logic [5:0] sig_r = 6'h00;
    assign wfi_o = sig_r[0];
    assign wfe_o = sig_r[1];
    assign exit_o = sig_r[2];
    assign irq_o = sig_r[3];
    assign event_o = {8{sig_r[4]}};
    assign pend_o = sig_r[5];
    // One-cycle pulse, all bits cleared again at the next clock edge
    task automatic pulse(input logic [5:0] v);
        @(posedge clk_i);
        sig_r <= v;
        @(posedge clk_i);
        sig_r <= 6'h00;
    endtask
endmodule

// file: sim/low_power_mode_controller_sva.sv
`timescale 1ns/100ps
// ********
// Mode checks
// ********
module lpm_sva (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic wfi_i,
    input wire logic wfe_i,
    input wire logic irq_accepted_i,
    input wire logic periph_irq_pend_i,
    input wire logic [7:0] ext_line_pend_i,
    input wire logic [7:0] ext_line_event_i,
    input wire logic rtc_alarm_flag_i,
    input wire logic flash_busy_i,
    input wire logic apb_busy_i,
    input wire logic wakeup_pin_i,
    input wire lpm_pkg::clk_ctl_s clk_ctl_o,
    input wire logic wdog_run_o,
    input wire logic wake_o,
    input wire logic standby_reset_o,
    input wire logic [1:0] mode_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_wfi_sleep;
        mode_o == 2'h0 && wfi_i ##1 mode_o == 2'h1;
    endsequence
    sequence s_wfe_sleep;
        mode_o == 2'h0 && wfe_i ##1 mode_o == 2'h1;
    endsequence
    a_sleep_clocks: assert property (mode_o == 2'h1 |-> !clk_ctl_o.cpu_clk_en
        && clk_ctl_o.domain_clk_en && clk_ctl_o.io_hold) else $error("sleep clocks wrong");
    a_stop_clocks: assert property (mode_o == 2'h2 |-> !clk_ctl_o.domain_clk_en && !clk_ctl_o.pll_en
        && !clk_ctl_o.hsi_en && !clk_ctl_o.hse_en && clk_ctl_o.io_hold) else $error("stop clocks wrong");
    a_standby_power: assert property (mode_o == 2'h3 |-> !clk_ctl_o.regulator_on
        && !clk_ctl_o.domain_power_on && !clk_ctl_o.hse_en) else $error("standby power wrong");
    a_wfi_wake: assert property (s_wfi_sleep ##1 irq_accepted_i |=> mode_o == 2'h0 && wake_o)
        else $error("irq did not wake");
    a_wfe_wake: assert property (s_wfe_sleep ##1 ext_line_event_i != 8'h00 |=> mode_o == 2'h0 && wake_o)
        else $error("event did not wake");
    a_stop_postpone: assert property (mode_o != 2'h2 && (flash_busy_i || apb_busy_i) |=> mode_o != 2'h2)
        else $error("stop entered while busy");
    a_stop_pending: assert property (mode_o == 2'h0 && (wfi_i || wfe_i)
        && (ext_line_pend_i != 8'h00 || periph_irq_pend_i || rtc_alarm_flag_i) |=> mode_o != 2'h2)
        else $error("stop entered with pending flag");
    a_stop_exit_hsi: assert property (mode_o == 2'h2 ##1 mode_o == 2'h0
        |-> clk_ctl_o.sysclk_src == lpm_pkg::SYSCLK_SRC_HSI && wake_o) else $error("stop exit clock wrong");
    a_wdog_sticky: assert property ($rose(wdog_run_o) |=> wdog_run_o [*8]) else $error("watchdog stopped");
    a_standby_wake: assert property (mode_o == 2'h3 && $rose(wakeup_pin_i) |-> ##[1:6] standby_reset_o)
        else $error("no standby wake");
endmodule
bind low_power_mode_controller lpm_sva sva (.*);

// file: sim/low_power_mode_controller_bench.sv
`timescale 1ns/100ps
module low_power_mode_controller_bench;
    // ********
    // Signals
    // ********
    logic clk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0, rdata_o;
    logic wfi_i, wfe_i, handler_exit_i, irq_accepted_i, periph_irq_pend_i;
    logic [7:0] ext_line_event_i, ext_line_pend_i = 8'h00;
    logic rtc_alarm_flag_i = 1'b0, flash_busy_i = 1'b0, apb_busy_i = 1'b0, wakeup_pin_i = 1'b0;
    logic rtc_alarm_i = 1'b0, ext_reset_pin_b_i = 1'b1, wdog_reset_i = 1'b0, wdog_hw_option_i = 1'b0;
    lpm_pkg::backup_ctl_s backup_ctl_i = 2'h0, backup_keep_o;
    lpm_pkg::clk_ctl_s clk_ctl_o;
    logic wdog_run_o, wake_o, standby_reset_o;
    logic [1:0] mode_o;
    int num_errors = 0, n_compared = 0;
    always #12.5 clk_i = ~clk_i;
    low_power_mode_controller dut (.*);
    lpm_cpu_model cpu (.clk_i(clk_i), .wfi_o(wfi_i), .wfe_o(wfe_i), .exit_o(handler_exit_i),
        .irq_o(irq_accepted_i), .pend_o(periph_irq_pend_i), .event_o(ext_line_event_i));
    // ********
    // Tasks
    // ********
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, exp);
    endtask
    // Packed view: mode, cpu, domain, hsi, regulator, io hold, wake
    function automatic logic [31:0] st();
        return {24'h0, mode_o, clk_ctl_o.cpu_clk_en, clk_ctl_o.domain_clk_en, clk_ctl_o.hsi_en,
            clk_ctl_o.regulator_on, clk_ctl_o.io_hold, wake_o};
    endfunction
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wait_sbrst();
        #1;
        for (int i = 0; i < 8 && standby_reset_o !== 1'b1; i++) settle(1);
    endtask
    task automatic wait_mode(input logic [1:0] m);
        #1;
        for (int i = 0; i < 8 && mode_o !== m; i++) settle(1);
    endtask
    task automatic reset_dut();
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        #1;
    endtask
    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #100us;
        num_errors++;
        summarize();
    end
    // ********
    // Tests
    // ********
    initial begin
        reset_dut();
        chk(st(), 32'h3C);
        chk(32'(clk_ctl_o.periph_clk_en), 32'hFF);
        wr(lpm_pkg::ADDR_STAT, 32'h1F);
        rd(lpm_pkg::ADDR_STAT, 32'h0);
        rd(4'h2, 32'h0);
        wr(lpm_pkg::ADDR_PCLK, 32'h5A);
        wr(lpm_pkg::ADDR_CTRL, 32'h60);
        settle(2);
        chk(32'({clk_ctl_o.periph_clk_en, clk_ctl_o.sysclk_div}), 32'h16B);
        wr(lpm_pkg::ADDR_CTRL, 32'h0);
        cpu.pulse(6'h01);
        #1 chk(st(), 32'h5E);
        chk(32'(clk_ctl_o.periph_clk_en), 32'h5A);
        cpu.pulse(6'h08);
        #1 chk(st(), 32'h3D);
        cpu.pulse(6'h02);
        cpu.pulse(6'h10);
        #1 chk(st(), 32'h3D);
        cpu.pulse(6'h02);
        cpu.pulse(6'h20);
        #1 chk(st(), 32'h5E);
        wr(lpm_pkg::ADDR_CTRL, 32'h4);
        rd(lpm_pkg::ADDR_STAT, {27'h0, lpm_pkg::MODE_SLEEP_EVT, lpm_pkg::STAT_SLEEP});
        cpu.pulse(6'h20);
        #1 chk(st(), 32'h3D);
        wr(lpm_pkg::ADDR_CTRL, 32'h2);
        cpu.pulse(6'h04);
        #1 chk(st(), 32'h5E);
        cpu.pulse(6'h08);
        #1 chk(st(), 32'h3D);
        wr(lpm_pkg::ADDR_CTRL, 32'h1);
        flash_busy_i <= 1'b1;
        cpu.pulse(6'h01);
        settle(3);
        chk(32'(mode_o), 32'h0);
        @(posedge clk_i);
        apb_busy_i <= 1'b1;
        flash_busy_i <= 1'b0;
        settle(3);
        chk(32'(mode_o), 32'h0);
        @(posedge clk_i);
        apb_busy_i <= 1'b0;
        wait_mode(2'h2);
        chk(st(), 32'h86);
        @(posedge clk_i);
        ext_line_pend_i <= 8'h01;
        wait_mode(2'h0);
        chk(st(), 32'h3D);
        chk(32'(clk_ctl_o.sysclk_src), 32'h0);
        @(posedge clk_i);
        ext_line_pend_i <= 8'h00;
        rtc_alarm_flag_i <= 1'b1;
        cpu.pulse(6'h01);
        settle(3);
        chk(32'(mode_o), 32'h0);
        @(posedge clk_i);
        rtc_alarm_flag_i <= 1'b0;
        backup_ctl_i <= 2'h2;
        wr(lpm_pkg::ADDR_WDOG, 32'h1);
        wr(lpm_pkg::ADDR_WDOG, 32'h0);
        settle(2);
        chk(32'({backup_keep_o, wdog_run_o}), 32'h5);
        wr(lpm_pkg::ADDR_CTRL, 32'h9);
        cpu.pulse(6'h01);
        wait_mode(2'h3);
        chk(32'({mode_o, clk_ctl_o.regulator_on, clk_ctl_o.domain_power_on, clk_ctl_o.hse_en}), 32'h18);
        @(posedge clk_i);
        wakeup_pin_i <= 1'b1;
        wait_sbrst();
        chk(32'(standby_reset_o), 32'h1);
        @(posedge clk_i);
        wakeup_pin_i <= 1'b0;
        rtc_alarm_i <= 1'b1;
        wait_sbrst();
        chk(32'(standby_reset_o), 32'h1);
        settle(2);
        chk(32'(standby_reset_o), 32'h0);
        @(posedge clk_i);
        wdog_reset_i <= 1'b1;
        wait_sbrst();
        chk(32'(standby_reset_o), 32'h1);
        @(posedge clk_i);
        wdog_reset_i <= 1'b0;
        ext_reset_pin_b_i <= 1'b0;
        settle(6);
        chk(32'(standby_reset_o), 32'h1);
        @(posedge clk_i);
        ext_reset_pin_b_i <= 1'b1;
        rtc_alarm_i <= 1'b0;
        reset_dut();
        chk(st(), 32'h3C);
        chk(32'({clk_ctl_o.periph_clk_en, wdog_run_o}), 32'h1FE);
        @(posedge clk_i);
        wdog_hw_option_i <= 1'b1;
        settle(4);
        chk(32'(wdog_run_o), 32'h1);
        summarize();
    end
endmodule
